//--- src/chopper_pkg.sv
package chopper_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [3:0] OFS_CTRL    = 4'h0;
   localparam logic [3:0] OFS_PWMCONF = 4'h1;
   localparam logic [3:0] OFS_HOLD    = 4'h2;
   localparam logic [3:0] OFS_STATUS  = 4'h3;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int CTRL_OFF_TIME_SETTING_LSB  = 0;
   localparam int CTRL_TBL_LSB   = 4;
   localparam int CTRL_SPREAD    = 6;
   localparam int CTRL_AUTO      = 7;
   localparam int CONF_OFS_LSB   = 0;
   localparam int CONF_GRAD_LSB  = 8;
   localparam int CONF_FREQ_LSB  = 16;
   localparam int CONF_REG_LSB   = 18;
   localparam int CONF_SS_LSB    = 22;
   localparam int ST_OFS_LSB     = 0;
   localparam int ST_GRAD_LSB    = 8;
   localparam int ST_CORR_LSB    = 16;
   localparam int ST_MODE        = 25;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [7:0]  CTRL_RST = 8'ha3;
   localparam logic [23:0] CONF_RST = 24'h11_0024;
   localparam logic [4:0]  HOLD_RST = 5'h10;

   ////////////////////////////////////////////////////////////////////////////
   // timing in system clocks, correction limit in half steps
   localparam logic [10:0] PWM_CYC_0      = 11'h400;
   localparam logic [10:0] PWM_CYC_1      = 11'h2ab;
   localparam logic [10:0] PWM_CYC_2      = 11'h200;
   localparam logic [10:0] PWM_CYC_3      = 11'h19a;
   localparam logic [8:0]  BLANK_CLKS_0   = 9'h010;
   localparam logic [8:0]  BLANK_CLKS_1   = 9'h018;
   localparam logic [8:0]  BLANK_CLKS_2   = 9'h020;
   localparam logic [8:0]  BLANK_CLKS_3   = 9'h028;
   localparam logic [8:0]  SLOW_BASE_CLKS = 9'h00c;
   localparam logic [8:0]  SLOW_STEP_CLKS = 9'h020;
   localparam logic [8:0]  FAST_MAX_CLKS  = 9'h040;
   localparam logic signed [9:0] CORR_LIM = 10'sh1fe;

   ////////////////////////////////////////////////////////////////////////////
   // bridge gates: bit0 hs_a, bit1 ls_a, bit2 hs_b, bit3 ls_b
   localparam logic [3:0] GATES_OFF    = 4'h0;
   localparam logic [3:0] GATES_ON     = 4'h9;
   localparam logic [3:0] GATES_SLOW   = 4'ha;
   localparam logic [3:0] GATES_FAST   = 4'h6;
   localparam logic [3:0] GATES_BRK_HS = 4'h5;

   localparam logic [1:0] SS_NORMAL = 2'h0;
   localparam logic [1:0] SS_FREE   = 2'h1;
   localparam logic [1:0] SS_LS     = 2'h2;
   localparam logic [1:0] SS_HS     = 2'h3;

   typedef enum logic [1:0] {PH_ON, PH_SLOW1, PH_FAST, PH_SLOW2} phase_e;
endpackage

//--- src/chop_if.sv
interface chop_if;
   logic       run;
   logic [3:0] off_time;
   logic [1:0] blank_sel;
   logic       comp;
   logic [3:0] gates;
   modport ctrl (output run, off_time, blank_sel, comp, input gates);
   modport coil (input run, off_time, blank_sel, comp, output gates);
endinterface

//--- src/coil_chopper.sv
module coil_chopper #(
   parameter logic [8:0] FAST_CLKS = chopper_pkg::FAST_MAX_CLKS
) (
   input wire logic clk,   // system clock
   input wire logic rst_n, // synced reset, low active
   chop_if.coil     ch     // config in, gates out
);
   import chopper_pkg::*;

   phase_e     phase_reg, phase_next;
   logic [8:0] tmr_reg, tmr_next;
   logic [3:0] gate_reg, gate_next;
   logic [8:0] slow_clks;
   logic [8:0] blank_clks;
   logic       blank_over;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      slow_clks = SLOW_BASE_CLKS + 9'(ch.off_time) * SLOW_STEP_CLKS;
      unique case (ch.blank_sel)
         2'h0: blank_clks = BLANK_CLKS_0;
         2'h1: blank_clks = BLANK_CLKS_1;
         2'h2: blank_clks = BLANK_CLKS_2;
         2'h3: blank_clks = BLANK_CLKS_3;
      endcase
      blank_over = (tmr_reg >= blank_clks);
   end

   always_comb begin
      phase_next = phase_reg;
      tmr_next   = (tmr_reg == 9'h1ff) ? tmr_reg : tmr_reg + 9'h001;
      if (!ch.run) begin
         phase_next = PH_ON;
      end else begin
         unique case (phase_reg)
            PH_ON: if (blank_over && ch.comp) phase_next = PH_SLOW1;
            PH_SLOW1: if (tmr_reg >= slow_clks - 9'h001) phase_next = PH_FAST;
            PH_FAST: begin
               if ((blank_over && ch.comp) || tmr_reg >= FAST_CLKS - 9'h001) begin
                  phase_next = PH_SLOW2;
               end
            end
            PH_SLOW2: if (tmr_reg >= slow_clks - 9'h001) phase_next = PH_ON;
         endcase
      end
      // timer restarts at every switch, which also re-arms blanking
      if (phase_next != phase_reg || !ch.run) tmr_next = 9'h000;
      unique case (phase_next)
         PH_ON:    gate_next = GATES_ON;
         PH_FAST:  gate_next = GATES_FAST;
         default:  gate_next = GATES_SLOW;
      endcase
      if (!ch.run) gate_next = GATES_OFF;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg <= PH_ON;
         tmr_reg   <= 9'h000;
         gate_reg  <= GATES_OFF;
      end else begin
         phase_reg <= phase_next;
         tmr_reg   <= tmr_next;
         gate_reg  <= gate_next;
      end
   end

   assign ch.gates = gate_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks: phase dwell measured independently of the timer
   phase_e     ast_prev_reg;
   logic [8:0] ast_dwell_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ast_prev_reg  <= PH_ON;
         ast_dwell_reg <= 9'h000;
      end else begin
         ast_prev_reg  <= phase_reg;
         ast_dwell_reg <= (phase_reg != ast_prev_reg) ? 9'h001 : ast_dwell_reg + 9'h001;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_SLOW1_LEN: assert property (
      (phase_reg == PH_FAST && ast_prev_reg == PH_SLOW1 && $stable(ch.off_time))
      |-> ast_dwell_reg == slow_clks) else $error("first slow decay length wrong");
   AST_SLOW2_LEN: assert property (
      (phase_reg == PH_ON && ast_prev_reg == PH_SLOW2 && $past(ch.run) && $stable(ch.off_time))
      |-> ast_dwell_reg == slow_clks) else $error("second slow decay length wrong");
   AST_ON_END: assert property (
      (phase_reg == PH_SLOW1 && ast_prev_reg == PH_ON)
      |-> ast_dwell_reg > blank_clks && $past(ch.comp)) else $error("on phase ended without comparator");
   AST_FAST_END: assert property (
      (phase_reg == PH_SLOW2 && ast_prev_reg == PH_FAST)
      |-> ast_dwell_reg == FAST_CLKS || (ast_dwell_reg > blank_clks && $past(ch.comp)))
      else $error("fast decay ended on wrong cause");
   AST_FAST_MAX: assert property (
      (phase_reg == PH_FAST && ast_prev_reg == PH_FAST) |-> ast_dwell_reg < FAST_CLKS)
      else $error("fast decay overran its timer");
   AST_ORDER: assert property (
      (phase_reg != ast_prev_reg && $past(ch.run))
      |-> phase_reg == phase_e'(2'(ast_prev_reg) + 2'h1)) else $error("phase order broken");

   COV_CYCLE: cover property (phase_reg == PH_ON && ast_prev_reg == PH_SLOW2);
   COV_FAST_TMR: cover property (phase_reg == PH_SLOW2 && ast_prev_reg == PH_FAST
                                 && ast_dwell_reg == FAST_CLKS);
endmodule

//--- src/stepper_chopper_pwm_control.sv
// Implementation choices: the placing of the registers and the plain strobed port.
module stepper_chopper_pwm_control (
   input  wire logic                           core_clk,       // system clock
   input  wire logic                           nrst,           // async reset, low active
   input  wire logic [chopper_pkg::ADDR_W-1:0] reg_addr,       // register index
   input  wire logic [chopper_pkg::DATA_W-1:0] reg_wdata,      // write data
   input  wire logic                           reg_wr,         // write strobe
   input  wire logic                           reg_rd,         // read strobe
   output      logic [chopper_pkg::DATA_W-1:0] reg_rdata,      // read data, next cycle
   input  wire logic                           spread_pin,     // mode select pin
   input  wire logic                           comp_a,         // coil a current reached
   input  wire logic                           comp_b,         // coil b current reached
   input  wire logic                           fullstep_tick,  // one pulse per fullstep
   input  wire logic                           otp_grad_valid, // preload present
   input  wire logic [7:0]                     otp_grad,       // preload gradient
   output      logic [3:0]                     bridge_a,       // coil a gates
   output      logic [3:0]                     bridge_b        // coil b gates
);
   import chopper_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // reset release
   logic [1:0] rst_sync_reg;
   logic       rst_n;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   function automatic logic [7:0] sat8(input logic signed [11:0] v);
      logic [7:0] r;
      if (v < 12'sh000) begin
         r = 8'h00;
      end else if (v > 12'sh0ff) begin
         r = 8'hff;
      end else begin
         r = v[7:0];
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // configuration registers
   logic [7:0]  ctrl_reg, ctrl_next;
   logic [23:0] conf_reg, conf_next;
   logic [4:0]  hold_reg, hold_next;
   logic        boot_reg, boot_next;

   always_comb begin
      ctrl_next = ctrl_reg;
      conf_next = conf_reg;
      hold_next = hold_reg;
      boot_next = 1'b1;
      // gradient preload caught once, first cycle after release
      if (!boot_reg && otp_grad_valid) conf_next[CONF_GRAD_LSB +: 8] = otp_grad;
      if (reg_wr) begin
         unique case (reg_addr)
            OFS_CTRL:    ctrl_next = reg_wdata[7:0];
            OFS_PWMCONF: conf_next = reg_wdata[23:0];
            OFS_HOLD:    hold_next = reg_wdata[4:0];
            default:     ;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= CTRL_RST;
         conf_reg <= CONF_RST;
         hold_reg <= HOLD_RST;
         boot_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         conf_reg <= conf_next;
         hold_reg <= hold_next;
         boot_reg <= boot_next;
      end
   end

   logic [3:0] off_time_setting;
   logic [1:0] blank_time_sel;
   logic       spread_cfg;
   logic       autoscale;
   logic [7:0] vpwm_offset_amp;
   logic [7:0] vpwm_gradient_amp;
   logic [1:0] vpwm_freq_sel;
   logic [3:0] reg_gradient;
   logic [1:0] standstill_option;
   logic [4:0] hold_current;

   assign off_time_setting  = ctrl_reg[CTRL_OFF_TIME_SETTING_LSB +: 4];
   assign blank_time_sel    = ctrl_reg[CTRL_TBL_LSB +: 2];
   assign spread_cfg        = ctrl_reg[CTRL_SPREAD];
   assign autoscale         = ctrl_reg[CTRL_AUTO];
   assign vpwm_offset_amp   = conf_reg[CONF_OFS_LSB +: 8];
   assign vpwm_gradient_amp = conf_reg[CONF_GRAD_LSB +: 8];
   assign vpwm_freq_sel     = conf_reg[CONF_FREQ_LSB +: 2];
   assign reg_gradient      = conf_reg[CONF_REG_LSB +: 4];
   assign standstill_option = conf_reg[CONF_SS_LSB +: 2];
   assign hold_current      = hold_reg;

   ////////////////////////////////////////////////////////////////////////////
   // mode select and scaling regulator
   logic              mode_reg, mode_next;
   logic signed [9:0] corr2_reg, corr2_next;
   logic              seen_reg, seen_next;
   logic [7:0]        tuned_ofs_reg, tuned_ofs_next;
   logic [7:0]        tuned_grad_reg, tuned_grad_next;
   logic [7:0]        amp_reg, amp_next;
   logic signed [9:0] step_s;
   logic signed [10:0] corr_sum;
   logic signed [8:0] corr_s;
   logic [13:0]       lin_prod;
   logic [7:0]        base_amp;
   logic              frozen;

   always_comb begin
      mode_next = spread_cfg ^ spread_pin;
      // regulation holds while current mode runs or target is zero
      frozen    = mode_reg || hold_current == 5'h00 || !autoscale;
      step_s    = {6'h00, reg_gradient};
      // correction kept in half steps: code G moves G/2 per fullstep
      corr_sum  = seen_reg ? 11'(corr2_reg) - 11'(step_s) : 11'(corr2_reg) + 11'(step_s);
      corr2_next = corr2_reg;
      if (fullstep_tick && !frozen) begin
         if (corr_sum > 11'(CORR_LIM)) begin
            corr2_next = CORR_LIM;
         end else if (corr_sum < -11'(CORR_LIM)) begin
            corr2_next = -CORR_LIM;
         end else begin
            corr2_next = corr_sum[9:0];
         end
      end
      // a comparator hit in the tick cycle still counts for the next step
      seen_next = (fullstep_tick ? 1'b0 : seen_reg) | comp_a | comp_b;
      corr_s    = 9'(corr2_reg >>> 1);
      lin_prod  = 14'(vpwm_offset_amp) * 14'({1'b0, hold_current} + 6'h01);
      // zero offset leaves the current setting out of the amplitude
      if (vpwm_offset_amp == 8'h00) begin
         base_amp = vpwm_gradient_amp;
      end else begin
         base_amp = sat8(12'(lin_prod[12:5]) + 12'(vpwm_gradient_amp));
      end
      amp_next = autoscale ? sat8($signed({4'h0, base_amp}) + 12'(corr_s)) : base_amp;
      // tuning seeds from the user settings
      tuned_ofs_next  = autoscale ? sat8($signed({4'h0, vpwm_offset_amp}) + 12'(corr_s))
                                  : vpwm_offset_amp;
      tuned_grad_next = autoscale ? sat8($signed({4'h0, vpwm_gradient_amp}) + 12'(corr_s >>> 2))
                                  : vpwm_gradient_amp;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg       <= 1'b0;
         corr2_reg      <= 10'sh000;
         seen_reg       <= 1'b0;
         tuned_ofs_reg  <= 8'h00;
         tuned_grad_reg <= 8'h00;
         amp_reg        <= 8'h00;
      end else begin
         mode_reg       <= mode_next;
         corr2_reg      <= corr2_next;
         seen_reg       <= seen_next;
         tuned_ofs_reg  <= tuned_ofs_next;
         tuned_grad_reg <= tuned_grad_next;
         amp_reg        <= amp_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // voltage-mode pwm: the on pulse repeats in each half period, both bridge halves drive in both
   logic [10:0] pwm_cnt_reg, pwm_cnt_next;
   logic [10:0] pwm_cyc;
   logic [10:0] pwm_half;
   logic [10:0] pwm_pos;
   logic [18:0] duty_prod;
   logic        first_half;
   logic [3:0]  vpwm_gates;

   always_comb begin
      unique case (vpwm_freq_sel)
         2'h0: pwm_cyc = PWM_CYC_0;
         2'h1: pwm_cyc = PWM_CYC_1;
         2'h2: pwm_cyc = PWM_CYC_2;
         2'h3: pwm_cyc = PWM_CYC_3;
      endcase
      pwm_cnt_next = (pwm_cnt_reg >= pwm_cyc - 11'h001) ? 11'h000 : pwm_cnt_reg + 11'h001;
      pwm_half     = pwm_cyc >> 1;
      first_half   = pwm_cnt_reg < pwm_half;
      pwm_pos      = first_half ? pwm_cnt_reg : pwm_cnt_reg - pwm_half;
      duty_prod    = 19'(amp_reg) * 19'(pwm_half);
      // recirculation alternates low side and high side per half
      if (pwm_pos < duty_prod[18:8]) begin
         vpwm_gates = GATES_ON;
      end else begin
         vpwm_gates = first_half ? GATES_SLOW : GATES_BRK_HS;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwm_cnt_reg <= 11'h000;
      end else begin
         pwm_cnt_reg <= pwm_cnt_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // current-mode choppers, one per coil
   logic [1:0] coil_comp;
   logic [3:0] coil_gates [2];

   assign coil_comp = {comp_b, comp_a};

   generate
      for (genvar i = 0; i < 2; i++) begin : g_coil
         chop_if ch ();
         assign ch.run       = mode_reg && off_time_setting != 4'h0;
         assign ch.off_time  = off_time_setting;
         assign ch.blank_sel = blank_time_sel;
         assign ch.comp      = coil_comp[i];
         assign coil_gates[i] = ch.gates;
         coil_chopper u_coil (
            .clk   (core_clk),
            .rst_n (rst_n),
            .ch    (ch)
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // gate selection
   logic [3:0] bridge_a_reg, bridge_a_next;
   logic [3:0] bridge_b_reg, bridge_b_next;
   logic [3:0] ss_gates;

   always_comb begin
      unique case (standstill_option)
         SS_LS:   ss_gates = GATES_SLOW;
         SS_HS:   ss_gates = GATES_BRK_HS;
         default: ss_gates = GATES_OFF;
      endcase
      if (off_time_setting == 4'h0) begin
         bridge_a_next = GATES_OFF;
         bridge_b_next = GATES_OFF;
      end else if (mode_reg) begin
         bridge_a_next = coil_gates[0];
         bridge_b_next = coil_gates[1];
      end else if (hold_current == 5'h00 && standstill_option != SS_NORMAL) begin
         bridge_a_next = ss_gates;
         bridge_b_next = ss_gates;
      end else begin
         bridge_a_next = vpwm_gates;
         bridge_b_next = vpwm_gates;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bridge_a_reg <= GATES_OFF;
         bridge_b_reg <= GATES_OFF;
      end else begin
         bridge_a_reg <= bridge_a_next;
         bridge_b_reg <= bridge_b_next;
      end
   end

   assign bridge_a = bridge_a_reg;
   assign bridge_b = bridge_b_reg;

   ////////////////////////////////////////////////////////////////////////////
   // register read
   logic [DATA_W-1:0] rdata_reg, rdata_next;

   always_comb begin
      rdata_next = 32'h0000_0000;
      if (reg_rd) begin
         unique case (reg_addr)
            OFS_CTRL:    rdata_next[7:0]  = ctrl_reg;
            OFS_PWMCONF: rdata_next[23:0] = conf_reg;
            OFS_HOLD:    rdata_next[4:0]  = hold_reg;
            OFS_STATUS: begin
               rdata_next[ST_OFS_LSB +: 8]  = tuned_ofs_reg;
               rdata_next[ST_GRAD_LSB +: 8] = tuned_grad_reg;
               rdata_next[ST_CORR_LSB +: 9] = corr_s;
               rdata_next[ST_MODE]          = mode_reg;
            end
            default:     ;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   AST_DRV_OFF: assert property (
      off_time_setting == 4'h0 |=> bridge_a == GATES_OFF && bridge_b == GATES_OFF)
      else $error("driver not off with zero off time");
   AST_MODE_SEL: assert property (
      rst_n |=> mode_reg == $past(spread_cfg ^ spread_pin)) else $error("mode select wrong");
   AST_FROZEN: assert property (
      mode_reg |=> $stable(corr2_reg)) else $error("correction moved in current mode");
   AST_CORR_RANGE: assert property (
      corr2_reg <= CORR_LIM && corr2_reg >= -CORR_LIM) else $error("correction out of range");
   AST_BRAKE_LS: assert property (
      (!mode_reg && off_time_setting != 4'h0 && hold_current == 5'h00 && standstill_option == SS_LS)
      |=> bridge_a == GATES_SLOW && bridge_b == GATES_SLOW) else $error("low side brake missing");
   AST_HALF_SPLIT: assert property (
      (!mode_reg && off_time_setting != 4'h0 && hold_current != 5'h00 && first_half)
      |=> !bridge_a[2] && !bridge_b[2]) else $error("second half driven in first half");
   AST_STEP_UP: assert property (
      (fullstep_tick && !frozen && !seen_reg && corr2_reg <= CORR_LIM - 10'sh00f)
      |=> corr2_reg == $past(corr2_reg) + $past(step_s)) else $error("regulator step wrong");

   COV_BRAKE_HS: cover property (!mode_reg && hold_current == 5'h00 && bridge_a == GATES_BRK_HS);
   COV_CORR_MOVE: cover property (fullstep_tick && !frozen ##1 $changed(corr2_reg));
endmodule

//--- bench/coil_model.sv
module coil_model #(
   parameter int RISE = 30, // on cycles to reach target
   parameter int FALL = 20  // fast decay cycles to trip
) (
   input  wire logic       clk,   // system clock
   input  wire logic [3:0] gates, // bridge gate drive
   output      logic       comp   // current reached target
);
   timeunit 1ns;
   timeprecision 1ps;
   import chopper_pkg::*;
   int         cnt  = 0;
   logic [3:0] last = 4'h0;
   always @(posedge clk) begin
      last <= gates;
      cnt  <= (gates == last) ? cnt + 1 : 1;
   end
   assign comp = (gates == GATES_ON && cnt >= RISE) || (gates == GATES_FAST && cnt >= FALL);
endmodule

//--- bench/stepper_chopper_pwm_control_tb.sv
module stepper_chopper_pwm_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import chopper_pkg::*;
   logic        core_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, spread_pin = 1'b0;
   logic [3:0]  reg_addr = 4'h0, bridge_a, bridge_b;
   logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, s;
   logic        comp_a, comp_b;
   logic        fullstep_tick = 1'b0, otp_grad_valid = 1'b1;
   logic [7:0]  otp_grad = 8'h5a; // preload value, arbitrary
   int          n_fail = 0, compares = 0, cyc = 0, n;
   always #4 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         wrap_up();
      end
   end
   stepper_chopper_pwm_control i_stepper_chopper_pwm_control (.core_clk(core_clk), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .spread_pin(spread_pin), .comp_a(comp_a), .comp_b(comp_b), .fullstep_tick(fullstep_tick),
      .otp_grad_valid(otp_grad_valid), .otp_grad(otp_grad), .bridge_a(bridge_a), .bridge_b(bridge_b));
   coil_model i_coil_model_a (.clk(core_clk), .gates(bridge_a), .comp(comp_a));
   coil_model #(.RISE(50), .FALL(999)) i_coil_model_b (.clk(core_clk), .gates(bridge_b), .comp(comp_b));
   ////////////////////////////////////////
   task automatic wrap_up;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic tick;
      @(posedge core_clk);
      #1;
   endtask
   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   function automatic logic [3:0] pat(bit b);
      return b ? bridge_b : bridge_a;
   endfunction
   // length of the next whole run of one gate pattern
   task automatic run_len(bit b, logic [3:0] p, output int k);
      k = 0;
      while (pat(b) === p) tick();
      while (pat(b) !== p) tick();
      while (pat(b) === p && k < 3000) begin
         tick();
         k++;
      end
   endtask
   ////////////////////////////////////////
   task automatic t_regs;
      rd(OFS_CTRL, s);
      chk("ctrl", 32'h0000_00a3, s);
      rd(OFS_PWMCONF, s);
      chk("pwmconf", 32'h0011_5a24, s);
      rd(OFS_HOLD, s);
      chk("hold", 32'h0000_0010, s);
      rd(OFS_STATUS, s);
      chk("status", 32'h0000_5a24, s);
      rd(4'h9, s);
      chk("unmapped", 32'h0000_0000, s);
      tick();
      chk("rdata idle", 32'h0000_0000, reg_rdata);
   endtask
   task automatic t_freq;
      int c[4] = '{1024, 683, 512, 410};
      for (int f = 0; f < 4; f++) begin
         wr(OFS_PWMCONF, (f << 16) | 32'h0000_8000);
         run_len(0, GATES_BRK_HS, n);
         run_len(0, GATES_ON, n);
         s = n;
         run_len(0, GATES_BRK_HS, n);
         chk("half period", c[f] / 2 + c[f] % 2, s + n);
      end
   endtask
   task automatic t_stand;
      logic [3:0] e[4] = '{GATES_ON, GATES_OFF, GATES_SLOW, GATES_BRK_HS};
      wr(OFS_HOLD, 32'h0000_0000);
      for (int o = 1; o < 4; o++) begin
         wr(OFS_PWMCONF, (o << 22) | 32'h0000_8000);
         repeat (4) tick();
         chk("standstill a", e[o], bridge_a);
         chk("standstill b", e[o], bridge_b);
      end
      wr(OFS_HOLD, 32'h0000_0010);
   endtask
   task automatic t_off;
      wr(OFS_CTRL, 32'h0000_0000);
      repeat (4) tick();
      chk("off a", 4'h0, bridge_a);
      chk("off b", 4'h0, bridge_b);
   endtask
   task automatic t_curr;
      wr(OFS_CTRL, 32'h0000_0001);
      spread_pin <= 1'b1;
      rd(OFS_STATUS, s);
      chk("mode pin", 1, s[ST_MODE]);
      run_len(0, GATES_SLOW, n);
      chk("slow1 a", 44, n);
      chk("after slow1", GATES_FAST, bridge_a);
      run_len(0, GATES_FAST, n);
      chk("fast by comp", 1, n < 64);
      chk("after fast", GATES_SLOW, bridge_a);
      // blank code 2: comparator already high, phase ends first cycle after 32 blanked clocks
      wr(OFS_CTRL, 32'h0000_0021);
      run_len(0, GATES_FAST, n);
      chk("fast blanked", 33, n);
      run_len(1, GATES_FAST, n);
      chk("fast by timer", 64, n);
      n = 0;
      while (bridge_b === GATES_SLOW && n < 3000) begin
         tick();
         n++;
      end
      chk("slow2 b", 44, n);
      chk("after slow2", GATES_ON, bridge_b);
      wr(OFS_CTRL, 32'h0000_0041);
      rd(OFS_STATUS, s);
      chk("mode xor", 0, s[ST_MODE]);
      spread_pin <= 1'b0;
   endtask
   task automatic t_reg;
      wr(OFS_PWMCONF, 32'h000f_0800);
      wr(OFS_HOLD, 32'h0000_0000);
      wr(OFS_CTRL, 32'h0000_0081);
      repeat (40) tick();
      // frozen tick only clears the comparator memory
      fullstep_tick <= 1'b1;
      tick();
      fullstep_tick <= 1'b0;
      wr(OFS_HOLD, 32'h0000_0010);
      // four fullsteps of 1.5 steps each, short on pulses keep comparators quiet
      repeat (4) begin
         fullstep_tick <= 1'b1;
         tick();
         fullstep_tick <= 1'b0;
         tick();
      end
      rd(OFS_STATUS, s);
      chk("regulator", 32'h0006_0906, s);
   endtask
   initial begin
      repeat (4) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_regs();
      t_freq();
      t_stand();
      t_off();
      t_curr();
      t_reg();
      wrap_up();
   end
endmodule
